// [core_pkg.sv]
// shared constants, encodings and types of the 14-bit instruction core
package core_pkg;
  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int FADDR_W = 7;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;

  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [PC_W-1:0] PC_STEP = 11'h001;
  localparam logic [PC_W-1:0] PC_SKIP = 11'h002;
  localparam logic [SP_W-1:0] SP_STEP = 3'h1;

  localparam logic [1:0] PFX_BYTE = 2'h0;
  localparam logic [1:0] PFX_BIT = 2'h1;
  localparam logic [1:0] PFX_JUMP = 2'h2;
  localparam logic [1:0] PFX_LIT = 2'h3;

  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLEAR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOVE = 4'h8;
  localparam logic [3:0] OP_COMP = 4'h9;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_RRC = 4'hC;
  localparam logic [3:0] OP_RLC = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;

  localparam logic [1:0] BOP_CLEAR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_SKIPCLR = 2'h2;
  localparam logic [1:0] BOP_SKIPSET = 2'h3;

  localparam logic [3:0] LOP_OR = 4'h8;
  localparam logic [3:0] LOP_AND = 4'h9;
  localparam logic [3:0] LOP_XOR = 4'hA;

  localparam logic [WORD_W-1:0] W_RETURN = 14'h0008;
  localparam logic [WORD_W-1:0] W_INT_RETURN = 14'h0009;
  localparam logic [WORD_W-1:0] W_WDT = 14'h0064;
  localparam logic [WORD_W-1:0] W_SLEEP = 14'h0063;

  localparam logic [FADDR_W-1:0] FILE_TIMER = 7'h01;
  localparam logic [FADDR_W-1:0] FILE_STATUS = 7'h03;
  localparam logic [FADDR_W-1:0] FILE_PORT = 7'h06;

  localparam int ST_C = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_Z = 2;

  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CORE = 12'h004;
  localparam logic [11:0] REG_ACC = 12'h008;
  localparam int CTRL_RUN = 0;

  typedef enum logic [1:0] {
    ST_HALT = 2'b00,
    ST_RUN = 2'b01,
    ST_SLEEP = 2'b10
  } core_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

// [core.sv]
// instruction decode and execute core with apb control slave
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module core
  import core_pkg::*;
(
  input wire logic pclk, // 250 MHz clock
  input wire logic presetn, // async reset, active low
  input wire apb_req_t apb, // apb request group
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic [PC_W-1:0] pmem_addr, // program memory address
  input wire logic [WORD_W-1:0] pmem_data, // program memory word
  input wire logic [DATA_W-1:0] port_pins, // io port pin levels
  output logic [DATA_W-1:0] port_latch, // io port output latch
  input wire logic prescaler_to_timer, // prescaler assigned to timer
  output logic prescaler_clear, // prescaler clear pulse
  output logic wdt_restart, // watchdog restart pulse
  input wire logic wake, // wake from standby
  output logic standby, // core in standby
  output logic gie, // global interrupt enable
  output logic instr_cycle // pulse at each instruction end
);
  core_state_t state;
  logic [1:0] q;
  logic flush;
  logic [PC_W-1:0] pc;
  logic [DATA_W-1:0] w;
  logic c, digit_carry_flag, z, timeout_flag, powerdown_flag;
  logic ctrl_run;
  logic [SP_W-1:0] sp;
  logic [PC_W-1:0] stack [0:STACK_DEPTH-1];
  logic [DATA_W-1:0] file_mem [0:(1<<FADDR_W)-1];
  logic exec, live, err;

  logic [WORD_W-1:0] ins;
  logic [FADDR_W-1:0] f;
  logic [DATA_W-1:0] fval, k, res, mask;
  logic to_dest, wr_w, wr_f, skip, jump, push, pop, do_wdt, do_sleep, set_gie;
  logic next_c, next_digit_carry_flag, next_z;
  logic [PC_W-1:0] target, next_pc;

  // digit carry, carry out and sum; subtraction feeds ~b with carry in
  function automatic logic [9:0] alu_add(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {n[4], s[8], s[7:0]};
  endfunction

  // file read: status assembled, port taken from the pins
  function automatic logic [7:0] file_read(input logic [FADDR_W-1:0] a);
    logic [7:0] v;
    v = file_mem[a];
    if (a == FILE_STATUS) begin
      v = {3'h0, timeout_flag, powerdown_flag, z, digit_carry_flag, c};
    end else if (a == FILE_PORT) begin
      v = port_pins;
    end
    return v;
  endfunction

  assign exec = (state == ST_RUN) && (q == PHASE_LAST);
  assign live = exec && !flush;
  assign ins = pmem_data;
  assign f = ins[FADDR_W-1:0];
  assign k = ins[DATA_W-1:0];
  assign mask = 8'h01 << ins[9:7];
  assign pmem_addr = pc;
  assign standby = (state == ST_SLEEP);
  assign instr_cycle = exec;

  always_comb begin
    fval = file_read(f);
    res = 8'h00;
    to_dest = 1'b0;
    wr_w = 1'b0;
    wr_f = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    do_wdt = 1'b0;
    do_sleep = 1'b0;
    set_gie = 1'b0;
    next_c = c;
    next_digit_carry_flag = digit_carry_flag;
    next_z = z;
    target = stack[SP_W'(sp - SP_STEP)];
    case (ins[13:12])
      PFX_BYTE: begin
        to_dest = 1'b1;
        case (ins[11:8])
          OP_ADD: {next_digit_carry_flag, next_c, res} = alu_add(fval, w, 1'b0);
          OP_SUB: {next_digit_carry_flag, next_c, res} = alu_add(fval, ~w, 1'b1);
          OP_AND: res = w & fval;
          OP_OR: res = w | fval;
          OP_XOR: res = w ^ fval;
          OP_RLC: {next_c, res} = {fval, c};
          OP_RRC: {res, next_c} = {c, fval};
          OP_DECSZ: begin
            res = fval - 8'h01;
            skip = (res == 8'h00);
          end
          OP_INCSZ: begin
            res = fval + 8'h01;
            skip = (res == 8'h00);
          end
          OP_INC: res = fval + 8'h01;
          OP_DEC: res = fval - 8'h01;
          OP_COMP: res = ~fval;
          OP_MOVE: res = fval;
          OP_SWAP: res = {fval[3:0], fval[7:4]};
          OP_CLEAR: res = 8'h00;
          default: begin
            to_dest = 1'b0;
            if (ins[7]) begin
              res = w;
              wr_f = 1'b1;
            end else if (ins == W_RETURN) begin
              pop = 1'b1;
              jump = 1'b1;
            end else if (ins == W_INT_RETURN) begin
              pop = 1'b1;
              jump = 1'b1;
              set_gie = 1'b1;
            end else if (ins == W_WDT) begin
              do_wdt = 1'b1;
            end else if (ins == W_SLEEP) begin
              do_sleep = 1'b1;
            end
          end
        endcase
        case (ins[11:8])
          OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_INC, OP_DEC, OP_COMP, OP_MOVE,
          OP_CLEAR: next_z = (res == 8'h00);
          default: next_z = z;
        endcase
      end
      PFX_BIT: begin
        case (ins[11:10])
          BOP_CLEAR: begin
            res = fval & ~mask;
            wr_f = 1'b1;
          end
          BOP_SET: begin
            res = fval | mask;
            wr_f = 1'b1;
          end
          BOP_SKIPCLR: skip = ((fval & mask) == 8'h00);
          default: skip = ((fval & mask) != 8'h00);
        endcase
      end
      PFX_JUMP: begin
        jump = 1'b1;
        push = !ins[11];
        target = ins[PC_W-1:0];
      end
      default: begin
        wr_w = 1'b1;
        casez (ins[11:8])
          4'b00??: res = k;
          4'b01??: begin
            res = k;
            pop = 1'b1;
            jump = 1'b1;
          end
          LOP_OR: res = w | k;
          LOP_AND: res = w & k;
          LOP_XOR: res = w ^ k;
          4'b110?: {next_digit_carry_flag, next_c, res} = alu_add(k, ~w, 1'b1);
          4'b111?: {next_digit_carry_flag, next_c, res} = alu_add(k, w, 1'b0);
          default: wr_w = 1'b0;
        endcase
        // the unused literal code writes nothing, so it must leave zero alone too
        if (wr_w && ins[11]) begin
          next_z = (res == 8'h00);
        end
      end
    endcase
    if (to_dest) begin
      wr_f = ins[7];
      wr_w = !ins[7];
    end
    // an explicit write to status wins over the instruction's own flags
    if (wr_f && f == FILE_STATUS) begin
      next_c = res[ST_C];
      next_digit_carry_flag = res[ST_DIGIT];
      next_z = res[ST_Z];
    end
    next_pc = jump ? target : (skip ? pc + PC_SKIP : pc + PC_STEP);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 2'h0;
    end else begin
      q <= q + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_HALT;
    end else if (!ctrl_run) begin
      state <= ST_HALT;
    end else begin
      case (state)
        ST_HALT: state <= ST_RUN;
        ST_RUN: if (live && do_sleep) state <= ST_SLEEP;
        ST_SLEEP: if (wake) state <= ST_RUN;
        default: state <= ST_HALT;
      endcase
    end
  end

  // the flushed cycle never moves pc: skips and branches already placed it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= PC_RESET;
      flush <= 1'b0;
    end else if (exec) begin
      if (flush) begin
        flush <= 1'b0;
      end else begin
        pc <= next_pc;
        flush <= skip || jump;
      end
    end
  end

  // stack wraps circularly; overflow silently overwrites the oldest entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp <= 3'h0;
    end else if (live && push) begin
      stack[sp] <= pc + PC_STEP;
      sp <= sp + SP_STEP;
    end else if (live && pop) begin
      sp <= sp - SP_STEP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w <= 8'h00;
      c <= 1'b0;
      digit_carry_flag <= 1'b0;
      z <= 1'b0;
      gie <= 1'b0;
    end else if (live) begin
      if (wr_w) w <= res;
      c <= next_c;
      digit_carry_flag <= next_digit_carry_flag;
      z <= next_z;
      if (set_gie) gie <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
      wdt_restart <= 1'b0;
    end else begin
      wdt_restart <= live && (do_wdt || do_sleep);
      if (live && do_wdt) begin
        timeout_flag <= 1'b1;
        powerdown_flag <= 1'b1;
      end else if (live && do_sleep) begin
        timeout_flag <= 1'b1;
        powerdown_flag <= 1'b0;
      end
    end
  end

  // file storage holds data only and needs no reset
  always_ff @(posedge pclk) begin
    if (live && wr_f && f != FILE_STATUS && f != FILE_PORT) begin
      file_mem[f] <= res;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_latch <= 8'h00;
      prescaler_clear <= 1'b0;
    end else begin
      if (live && wr_f && f == FILE_PORT) port_latch <= res;
      prescaler_clear <= live && wr_f && f == FILE_TIMER && prescaler_to_timer;
    end
  end

  // apb: zero wait states, read data captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = err && apb.psel && apb.penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      err <= 1'b0;
      ctrl_run <= 1'b0;
    end else begin
      if (apb.psel && !apb.penable) begin
        err <= 1'b0;
        case (apb.paddr)
          REG_CTRL: prdata <= {31'h00000000, ctrl_run};
          REG_CORE: prdata <= {16'h0000, 3'h0, state, pc};
          REG_ACC: prdata <= {8'h00, file_read(FILE_STATUS), 8'h00, w};
          default: begin
            prdata <= 32'h00000000;
            err <= 1'b1;
          end
        endcase
      end
      if (apb.psel && apb.penable && apb.pwrite && apb.paddr == REG_CTRL) begin
        ctrl_run <= apb.pwdata[CTRL_RUN];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_phase_gap: assert property (exec |=> !exec [*3]) else $error("exec spacing");
  a_flush_nop: assert property (exec && flush |=> $stable(w) && pc == $past(pc))
    else $error("flushed cycle changed state");
  a_skip_flush: assert property (live && skip && !jump |=> flush && pc == $past(pc) + PC_SKIP)
    else $error("skip not taken");
  a_jump_pc: assert property (live && ins[13:12] == PFX_JUMP |=> flush && pc == $past(ins[10:0]))
    else $error("jump target wrong");
  a_call_push: assert property (live && ins[13:11] == 3'b100 |=> sp == SP_W'($past(sp) + SP_STEP))
    else $error("call did not push");
  a_bit_flags: assert property (live && ins[13:12] == PFX_BIT && f != FILE_STATUS
    |=> $stable({c, digit_carry_flag, z})) else $error("bit op changed flags");
  a_clear_zero: assert property (live && ins[13:8] == 6'h01 |=> z)
    else $error("clear did not set zero");
  a_wdt_flags: assert property (live && ins == W_WDT |=> timeout_flag && powerdown_flag
    && wdt_restart) else $error("watchdog restart flags");
  a_sleep_enter: assert property (live && ins == W_SLEEP && ctrl_run
    |=> state == ST_SLEEP && !powerdown_flag) else $error("sleep not entered");
  a_timer_clear: assert property (live && wr_f && f == FILE_TIMER && prescaler_to_timer
    |=> prescaler_clear) else $error("prescaler not cleared");
  a_dest_acc: assert property (live && ins[13:12] == PFX_BYTE && ins[11:8] == OP_ADD && !ins[7]
    |=> w == $past(res)) else $error("acc destination wrong");
  a_port_pins: assert property (live && ins[13:7] == 7'h11 && f == FILE_PORT
    |=> port_latch == $past(port_pins)) else $error("port read from latch");

  c_skip_taken: cover property (live && skip ##4 exec && flush);
  c_call_return: cover property (live && push ##[4:200] live && pop);
  c_sleep_wake: cover property (state == ST_SLEEP ##[1:50] state == ST_RUN);
endmodule

// [prog_mem.sv]
// program memory model that feeds 14-bit instruction words to the core
`timescale 1ns/100ps
module prog_mem
  import core_pkg::*;
(
  input wire logic [PC_W-1:0] addr, // fetch address
  output logic [WORD_W-1:0] data // word at addr
);
  logic [WORD_W-1:0] words [2**PC_W];
  // asynchronous read, so the word is settled well before the core's exec edge
  assign data = words[addr];
endmodule

// [risc_14bit_instruction_decoder_tb.sv]
// self-checking testbench of the instruction core with its program memory
`timescale 1ns/100ps
module risc_14bit_instruction_decoder_tb
  import core_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t bus = '0;
  logic [31:0] prdata;
  logic pready, pslverr, prescaler_clear, wdt_restart, standby, gie, instr_cycle;
  logic [PC_W-1:0] pmem_addr;
  logic [WORD_W-1:0] pmem_data;
  logic [DATA_W-1:0] port_pins = 8'h0F;
  logic [DATA_W-1:0] port_latch;
  logic prescaler_to_timer = 1'b1;
  logic wake = 1'b0;
  int bad_count = 0;
  int tests_run = 0;
  int clears = 0;
  int restarts = 0;
  int execs = 0;
  logic [31:0] rd;
  logic er;

  core DUT (.pclk(pclk), .presetn(presetn), .apb(bus), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_data(pmem_data), .port_pins(port_pins),
    .port_latch(port_latch), .prescaler_to_timer(prescaler_to_timer),
    .prescaler_clear(prescaler_clear), .wdt_restart(wdt_restart), .wake(wake),
    .standby(standby), .gie(gie), .instr_cycle(instr_cycle));
  prog_mem PM (.addr(pmem_addr), .data(pmem_data));

  always #2 pclk = ~pclk;

  always @(posedge pclk) begin
    if (prescaler_clear === 1'b1) clears <= clears + 1;
    if (wdt_restart === 1'b1) restarts <= restarts + 1;
    if (instr_cycle === 1'b1) execs <= execs + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    bus <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    bus.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    bus <= '0;
  endtask

  // reset first: a running core would otherwise fetch half-loaded code
  task automatic start(input logic [13:0] p[$]);
    presetn <= 1'b0;
    @(posedge pclk);
    foreach (PM.words[i]) PM.words[i] = '0;
    foreach (p[i]) PM.words[i] = p[i];
    @(posedge pclk);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h0000_0001);
  endtask

  task automatic gap(input logic [PC_W-1:0] from, to, input int exp);
    int n;
    int e0;
    n = 0;
    for (int i = 0; i < 400 && pmem_addr !== from; i++) @(posedge pclk);
    e0 = execs;
    while (pmem_addr !== to && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(n, exp);
    chk(execs - e0, exp / 4);
  endtask

  task automatic ending(input logic [31:0] acc, input logic [31:0] core_v);
    repeat (40) @(posedge pclk);
    apb(1'b0, REG_ACC, 32'h0);
    chk(rd, acc);
    apb(1'b0, REG_CORE, 32'h0);
    chk(rd, core_v);
  endtask

  task automatic t_arith;
    start('{14'h300F, 14'h3E01, 14'h00FF, 14'h3C10, 14'h027F, 14'h07FF, 14'h087F, 14'h2807});
    gap(1, 2, 4);
    ending(32'h0018_0020, 32'h0000_0807);
    $display("arith test done");
  endtask

  task automatic t_rotate;
    start('{14'h3081, 14'h00A0, 14'h0DA0, 14'h0C20, 14'h0E20, 14'h3001, 14'h00A1, 14'h0BA1,
      14'h3055, 14'h0FA1, 14'h0321, 14'h280B});
    gap(7, 9, 4);
    gap(9, 10, 8);
    ending(32'h001C_0000, 32'h0000_080B);
    $display("rotate test done");
  endtask

  task automatic t_bits;
    start('{14'h30F0, 14'h00A2, 14'h3E10, 14'h1222, 14'h1A22, 14'h3077, 14'h1EA2, 14'h3066,
      14'h1422, 14'h3A0F, 14'h0522, 14'h0422, 14'h0622, 14'h38A5, 14'h39F0, 14'h0722,
      14'h2810});
    gap(4, 6, 4);
    gap(6, 8, 8);
    ending(32'h0019_0081, 32'h0000_0810);
    $display("bit test done");
  endtask

  task automatic t_calls;
    start('{14'h2004, 14'h2005, 14'h2006, 14'h2803, 14'h0008, 14'h3455, 14'h0009});
    gap(4, 1, 8);
    gap(1, 5, 8);
    ending(32'h0018_0055, 32'h0000_0803);
    chk({31'h0, gie}, 32'h0000_0001);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, er}, 32'h0000_0001);
    $display("call test done");
  endtask

  task automatic t_power;
    int c0;
    int r0;
    c0 = clears;
    r0 = restarts;
    start('{14'h30FF, 14'h0086, 14'h0886, 14'h0A81, 14'h0190, 14'h0103, 14'h0063, 14'h0064,
      14'h0081, 14'h2809});
    for (int i = 0; i < 200 && standby !== 1'b1; i++) @(posedge pclk);
    chk({31'h0, standby}, 32'h0000_0001);
    apb(1'b0, REG_ACC, 32'h0);
    chk(rd, 32'h0014_0000);
    chk({24'h0, port_latch}, 32'h0000_000F);
    // the timer store after wake must not clear a prescaler owned elsewhere
    wake <= 1'b1;
    prescaler_to_timer <= 1'b0;
    for (int i = 0; i < 200 && standby !== 1'b0; i++) @(posedge pclk);
    wake <= 1'b0;
    ending(32'h001C_0000, 32'h0000_0809);
    chk(clears - c0, 32'h0000_0001);
    chk(restarts - r0, 32'h0000_0002);
    $display("power test done");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    t_arith;
    t_rotate;
    t_bits;
    t_calls;
    t_power;
    conclude;
  end

  // the whole run needs a few hundred cycles; this cuts a hang short
  initial begin
    #100000;
    bad_count++;
    conclude;
  end
endmodule
